// >>> rtl/jcc_consts.svh
// Constants of the link configuration checker: register address, band values, limits
// Assumes lane rate in half-Mbps units and sample clock in MHz
`ifndef JCC_CONSTS_SVH
`define JCC_CONSTS_SVH
// ************************************************************
// Device register and band codes
// ************************************************************
`define JCC_BAND_REG_ADDR 16'h056E
`define JCC_BAND_HIGH     8'h30
`define JCC_BAND_MID      8'h10
`define JCC_BAND_LOW      8'h00
// ************************************************************
// Lane rate thresholds in half-Mbps units
// ************************************************************
`define JCC_SLR_MIN_H     32'h0000_0D2F
`define JCC_SLR_MAX_H     32'h0000_7918
`define JCC_SLR_B1_H      32'h0000_1A5E
`define JCC_SLR_B2_H      32'h0000_34BC
`define JCC_SLR_B3_H      32'h0000_6978
// ************************************************************
// Ratios and limits
// ************************************************************
`define JCC_SCLK_RATIO_H  32'h0000_0050
`define JCC_LCM_RATIO_H   32'h0000_0028
`define JCC_LCM_MAX       7'h40
`define JCC_ENC_NUM       32'h0000_000A
`define JCC_ENC_DEN       32'h0000_0008
`define JCC_K_MAX         6'h20
`define JCC_N_MIN         5'h08
`define JCC_CS_MAX        2'h3
`define JCC_WORD_16       5'h10
`define JCC_WORD_12       5'h0C
`endif

// >>> rtl/jcc_pkg.sv
// Types shared by the link configuration checker
// Assumes jcc_consts.svh carries the register address, band codes and limit constants
package jcc_pkg;
	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		JCC_ST_IDLE  = 5'b00001,
		JCC_ST_DIV   = 5'b00010,
		JCC_ST_LCM   = 5'b00100,
		JCC_ST_WRITE = 5'b01000,
		JCC_ST_DONE  = 5'b10000
	} jcc_state_e;
	// Error flag vector
	typedef logic [7:0] jcc_err_t;
endpackage : jcc_pkg

// >>> rtl/jcc_seq_div.sv
// Sequential restoring divider, one quotient bit per clock
// Assumes start is a one-cycle pulse while idle
`timescale 1ns/100ps
module jcc_seq_div #(
	parameter int W = 20
) (
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	input  wire logic         start,
	input  wire logic [W-1:0] dividend,
	input  wire logic [W-1:0] divisor,
	output logic              done,
	output logic [W-1:0]      quotient,
	output logic [W-1:0]      remainder
);
	logic [W-1:0] quo_reg, quo_next;
	logic [W:0]   rem_reg, rem_next;
	logic [W-1:0] dsr_reg, dsr_next;
	logic [5:0]   cnt_reg, cnt_next;
	logic         run_reg, run_next;
	logic         done_reg, done_next;
	logic [W:0]   trial;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		quo_next  = quo_reg;
		rem_next  = rem_reg;
		dsr_next  = dsr_reg;
		cnt_next  = cnt_reg;
		run_next  = run_reg;
		done_next = 1'b0;
		trial     = {rem_reg[W-1:0], quo_reg[W-1]};
		if (start && !run_reg) begin
			quo_next = dividend;
			rem_next = '0;
			dsr_next = divisor;
			cnt_next = 6'(W);
			run_next = 1'b1;
		end else if (run_reg) begin
			// Shift in next dividend bit, subtract if it fits
			if (trial >= {1'b0, dsr_reg}) begin
				rem_next = trial - {1'b0, dsr_reg};
				quo_next = {quo_reg[W-2:0], 1'b1};
			end else begin
				rem_next = trial;
				quo_next = {quo_reg[W-2:0], 1'b0};
			end
			cnt_next = cnt_reg - 6'h01;
			if (cnt_reg == 6'h01) begin
				run_next  = 1'b0;
				done_next = 1'b1;
			end
		end
	end

	// Registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			quo_reg  <= '0;
			rem_reg  <= '0;
			dsr_reg  <= '0;
			cnt_reg  <= 6'h00;
			run_reg  <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			quo_reg  <= quo_next;
			rem_reg  <= rem_next;
			dsr_reg  <= dsr_next;
			cnt_reg  <= cnt_next;
			run_reg  <= run_next;
			done_reg <= done_next;
		end
	end

	assign done      = done_reg;
	assign quotient  = quo_reg;
	assign remainder = rem_reg[W-1:0];
endmodule : jcc_seq_div

// >>> rtl/jcc_link_checker.sv
// Link configuration checker and rate-band writer for the converter output link
// Assumes user ports on clk_sys; device register write port is a plain strobe
`timescale 1ns/100ps
`include "jcc_consts.svh"
module jcc_link_checker #(
	parameter int FW = 13,
	parameter int DW = 6,
	parameter int RW = 15
) (
	input  wire logic          clk_sys,
	input  wire logic          resetn,
	input  wire logic          cfg_start,
	input  wire logic [FW-1:0] cfg_adc_clk_mhz,
	input  wire logic [DW-1:0] cfg_chip_decimation_ratio,
	input  wire logic [RW-1:0] cfg_serial_lane_rate_hmbps,
	input  wire logic [4:0]    cfg_lanes,
	input  wire logic [4:0]    cfg_convs,
	input  wire logic [4:0]    cfg_octets,
	input  wire logic [3:0]    cfg_samples,
	input  wire logic          cfg_hd,
	input  wire logic [4:0]    cfg_res,
	input  wire logic [4:0]    cfg_word,
	input  wire logic [1:0]    cfg_ctrl_bits,
	input  wire logic [5:0]    cfg_frames,
	output logic               busy,
	output logic               done,
	output logic               cfg_ok,
	output jcc_pkg::jcc_err_t  err_flags,
	output logic [7:0]         band_value,
	output logic               dev_wr_stb,
	output logic [15:0]        dev_addr,
	output logic [7:0]         dev_wdata
);
	import jcc_pkg::*;

	localparam int DVW = 20;

	jcc_state_e     st_reg, st_next;
	logic [FW-1:0]  fadc_reg, fadc_next;
	logic [DW-1:0]  dcm_reg, dcm_next;
	logic [RW-1:0]  slr_reg, slr_next;
	logic [4:0]     l_reg, l_next, m_reg, m_next, f_reg, f_next, n_reg, n_next, np_reg, np_next;
	logic [3:0]     s_reg, s_next;
	logic           hd_reg, hd_next;
	logic [1:0]     cs_reg, cs_next;
	logic [5:0]     k_reg, k_next;
	logic [6:0]     ra_reg, ra_next, rd_reg, rd_next, cnt_reg, cnt_next, r_reg, r_next;
	jcc_err_t       err_reg, err_next;
	logic           busy_reg, busy_next, done_reg, done_next, ok_reg, ok_next, stb_reg, stb_next;
	logic [7:0]     band_reg, band_next;
	logic [15:0]    addr_reg, addr_next;
	logic           div_start, div_done;
	logic [DVW-1:0] div_quo, div_rem;
	logic [63:0]    tab_mask;
	logic           tab_hit;
	logic [3:0]     dcm_idx;
	logic           dcm_listed;
	logic [1:0]     band_idx;
	logic [5:0]     k_min;
	logic [7:0]     band_sel;
	logic [31:0]    slr_w, lane_lhs, lane_rhs;
	logic           e_rate, e_sclk, e_kf, e_mode, e_dcm, e_lane, e_ratio;

	// Mode key from transport fields
	function automatic logic [20:0] mk(input int w, input int l, input int m, input int f, input int s, input int h);
		mk = {w[0], l[4:0], m[4:0], f[4:0], s[3:0], h[0]};
	endfunction : mk

	// ************************************************************
	// Mode table: decimation masks per lane band {b3,b2,b1,b0}
	// ************************************************************
	always_comb begin
		tab_hit  = 1'b1;
		tab_mask = 64'h0000_0000_0000_0000;
		case ({np_reg == `JCC_WORD_16, l_reg, m_reg, f_reg, s_reg, hd_reg})
			mk(1, 8, 8, 4, 2, 0): tab_mask = 64'h000A_006A_05EA_1DEA;
			mk(0, 1, 1, 3, 2, 0),
			mk(0, 2, 2, 3, 2, 0),
			mk(0, 4, 4, 3, 2, 0): tab_mask = 64'h0000_0024_0124_0124;
			mk(0, 2, 1, 3, 4, 1),
			mk(0, 2, 1, 6, 8, 0),
			mk(0, 4, 2, 3, 4, 0): tab_mask = 64'h0000_0004_0024_0024;
			mk(0, 3, 1, 1, 2, 1): tab_mask = 64'h0001_0003_000F_007F;
			mk(0, 1, 2, 3, 1, 0),
			mk(0, 2, 4, 3, 1, 0): tab_mask = 64'h0000_0124_1124_1124;
			mk(0, 3, 2, 1, 1, 1): tab_mask = 64'h0003_000F_007F_05FF;
			mk(0, 1, 4, 6, 1, 0): tab_mask = 64'h0000_1124_9124_9120;
			mk(0, 3, 4, 2, 1, 1): tab_mask = 64'h000F_007F_05FF_1DFA;
			mk(0, 2, 8, 6, 1, 0): tab_mask = 64'h0000_1120_9120_9120;
			mk(0, 4, 8, 3, 1, 0): tab_mask = 64'h0000_0120_1120_1120;
			default:              tab_hit  = 1'b0;
		endcase
	end

	// Decimation ratio to mask bit position
	always_comb begin
		dcm_listed = 1'b1;
		case (dcm_reg)
			6'h01:   dcm_idx = 4'h0;
			6'h02:   dcm_idx = 4'h1;
			6'h03:   dcm_idx = 4'h2;
			6'h04:   dcm_idx = 4'h3;
			6'h05:   dcm_idx = 4'h4;
			6'h06:   dcm_idx = 4'h5;
			6'h08:   dcm_idx = 4'h6;
			6'h0A:   dcm_idx = 4'h7;
			6'h0C:   dcm_idx = 4'h8;
			6'h0F:   dcm_idx = 4'h9;
			6'h10:   dcm_idx = 4'hA;
			6'h14:   dcm_idx = 4'hB;
			6'h18:   dcm_idx = 4'hC;
			6'h1E:   dcm_idx = 4'hD;
			6'h28:   dcm_idx = 4'hE;
			6'h30:   dcm_idx = 4'hF;
			default: begin
				dcm_idx    = 4'h0;
				dcm_listed = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// Static checks on the captured configuration
	// ************************************************************
	always_comb begin
		slr_w = 32'(slr_reg);
		e_rate = (slr_w < `JCC_SLR_MIN_H) || (slr_w > `JCC_SLR_MAX_H);
		e_sclk = slr_w > `JCC_SCLK_RATIO_H * 32'(fadc_reg);
		// Lane band index
		if (slr_w < `JCC_SLR_B1_H)
			band_idx = 2'h0;
		else if (slr_w < `JCC_SLR_B2_H)
			band_idx = 2'h1;
		else if (slr_w <= `JCC_SLR_B3_H)
			band_idx = 2'h2;
		else
			band_idx = 2'h3;
		// Band register value
		if (slr_w > `JCC_SLR_B3_H)
			band_sel = `JCC_BAND_HIGH;
		else if (slr_w >= `JCC_SLR_B1_H)
			band_sel = `JCC_BAND_MID;
		else
			band_sel = `JCC_BAND_LOW;
		// Least K for each octet count
		case (f_reg)
			5'h01:   k_min = 6'h14;
			5'h02:   k_min = 6'h0C;
			5'h04:   k_min = 6'h08;
			default: k_min = 6'h04;
		endcase
		e_kf = (k_reg[1:0] != 2'h0) || (k_reg > `JCC_K_MAX) || (k_reg < k_min)
			|| (7'((k_reg * f_reg) & 11'h003) != 7'h00);
		e_mode = !tab_hit || (n_reg < `JCC_N_MIN) || (n_reg > np_reg) || (cs_reg > `JCC_CS_MAX)
			|| ((np_reg != `JCC_WORD_16) && (np_reg != `JCC_WORD_12));
		e_dcm = !dcm_listed || !tab_mask[{band_idx, dcm_idx}];
		// Lane rate must match M*N'*10/8*fadc/(L*dcm), in half-Mbps units
		lane_lhs = slr_w * `JCC_ENC_DEN * 32'(l_reg) * 32'(dcm_reg);
		lane_rhs = 32'h0000_0002 * `JCC_ENC_NUM * 32'(m_reg) * 32'(np_reg) * 32'(fadc_reg);
		e_lane = lane_lhs != lane_rhs;
		e_ratio = (dcm_reg == '0) || (slr_reg == '0) || (div_rem != '0) || (div_quo == '0);
	end

	// Ratio 20*dcm*fout/SERIAL_LANE_RATE = 40*fadc/slr_half
	assign div_start = (st_reg == JCC_ST_IDLE) && cfg_start;

	jcc_seq_div #(
		.W(DVW)
	) u_div (
		.clk_sys   (clk_sys),
		.resetn    (resetn),
		.start     (div_start),
		.dividend  (DVW'(`JCC_LCM_RATIO_H * 32'(cfg_adc_clk_mhz))),
		.divisor   (DVW'(cfg_serial_lane_rate_hmbps)),
		.done      (div_done),
		.quotient  (div_quo),
		.remainder (div_rem)
	);

	// ************************************************************
	// Sequencer next state
	// ************************************************************
	always_comb begin
		st_next   = st_reg;
		fadc_next = fadc_reg;
		dcm_next  = dcm_reg;
		slr_next  = slr_reg;
		l_next    = l_reg;
		m_next    = m_reg;
		f_next    = f_reg;
		s_next    = s_reg;
		hd_next   = hd_reg;
		n_next    = n_reg;
		np_next   = np_reg;
		cs_next   = cs_reg;
		k_next    = k_reg;
		ra_next   = ra_reg;
		rd_next   = rd_reg;
		cnt_next  = cnt_reg;
		r_next    = r_reg;
		err_next  = err_reg;
		busy_next = busy_reg;
		ok_next   = ok_reg;
		band_next = band_reg;
		addr_next = `JCC_BAND_REG_ADDR;
		done_next = 1'b0;
		stb_next  = 1'b0;
		case (st_reg)
			JCC_ST_IDLE: begin
				if (cfg_start) begin
					fadc_next = cfg_adc_clk_mhz;
					dcm_next  = cfg_chip_decimation_ratio;
					slr_next  = cfg_serial_lane_rate_hmbps;
					l_next    = cfg_lanes;
					m_next    = cfg_convs;
					f_next    = cfg_octets;
					s_next    = cfg_samples;
					hd_next   = cfg_hd;
					n_next    = cfg_res;
					np_next   = cfg_word;
					cs_next   = cfg_ctrl_bits;
					k_next    = cfg_frames;
					busy_next = 1'b1;
					ok_next   = 1'b0;
					st_next   = JCC_ST_DIV;
				end
			end
			JCC_ST_DIV: begin
				if (div_done) begin
					err_next  = {e_ratio, e_lane, e_dcm, e_mode, e_kf, 1'b0, e_sclk, e_rate};
					band_next = band_sel;
					ra_next   = 7'h00;
					rd_next   = 7'h00;
					cnt_next  = 7'h00;
					r_next    = 7'(div_quo);
					// Ratio not an integer or beyond the limit fails the multiple search
					if (e_ratio || (div_quo > DVW'(`JCC_LCM_MAX))) begin
						err_next[2] = 1'b1;
						st_next     = JCC_ST_DONE;
					end else begin
						st_next = JCC_ST_LCM;
					end
				end
			end
			JCC_ST_LCM: begin
				// Step common count until both residues wrap together
				cnt_next = cnt_reg + 7'h01;
				ra_next  = (ra_reg + 7'h01 == r_reg) ? 7'h00 : ra_reg + 7'h01;
				rd_next  = (rd_reg + 7'h01 == 7'(dcm_reg)) ? 7'h00 : rd_reg + 7'h01;
				if (ra_next == 7'h00 && rd_next == 7'h00)
					st_next = (err_reg == '0) ? JCC_ST_WRITE : JCC_ST_DONE;
				else if (cnt_next == `JCC_LCM_MAX) begin
					err_next[2] = 1'b1;
					st_next     = JCC_ST_DONE;
				end
			end
			JCC_ST_WRITE: begin
				stb_next = 1'b1;
				st_next  = JCC_ST_DONE;
			end
			JCC_ST_DONE: begin
				done_next = 1'b1;
				busy_next = 1'b0;
				ok_next   = (err_reg == '0);
				st_next   = JCC_ST_IDLE;
			end
			default: st_next = JCC_ST_IDLE;
		endcase
	end

	// Registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			st_reg   <= JCC_ST_IDLE;
			fadc_reg <= '0;
			dcm_reg  <= '0;
			slr_reg  <= '0;
			l_reg    <= 5'h00;
			m_reg    <= 5'h00;
			f_reg    <= 5'h00;
			s_reg    <= 4'h0;
			hd_reg   <= 1'b0;
			n_reg    <= 5'h00;
			np_reg   <= 5'h00;
			cs_reg   <= 2'h0;
			k_reg    <= 6'h00;
			ra_reg   <= 7'h00;
			rd_reg   <= 7'h00;
			cnt_reg  <= 7'h00;
			r_reg    <= 7'h00;
			err_reg  <= 8'h00;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			ok_reg   <= 1'b0;
			stb_reg  <= 1'b0;
			band_reg <= 8'h00;
			addr_reg <= 16'h0000;
		end else begin
			st_reg   <= st_next;
			fadc_reg <= fadc_next;
			dcm_reg  <= dcm_next;
			slr_reg  <= slr_next;
			l_reg    <= l_next;
			m_reg    <= m_next;
			f_reg    <= f_next;
			s_reg    <= s_next;
			hd_reg   <= hd_next;
			n_reg    <= n_next;
			np_reg   <= np_next;
			cs_reg   <= cs_next;
			k_reg    <= k_next;
			ra_reg   <= ra_next;
			rd_reg   <= rd_next;
			cnt_reg  <= cnt_next;
			r_reg    <= r_next;
			err_reg  <= err_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			ok_reg   <= ok_next;
			stb_reg  <= stb_next;
			band_reg <= band_next;
			addr_reg <= addr_next;
		end
	end

	// Outputs straight from flops
	assign busy       = busy_reg;
	assign done       = done_reg;
	assign cfg_ok     = ok_reg;
	assign err_flags  = err_reg;
	assign band_value = band_reg;
	assign dev_wr_stb = stb_reg;
	assign dev_addr   = addr_reg;
	assign dev_wdata  = band_reg;
endmodule : jcc_link_checker

// >>> sim/jcc_link_checker_sva.sv
// Port checker of the link configuration checker
// Assumes binding to jcc_link_checker; one clock, reset active low
`timescale 1ns/100ps
module jcc_link_checker_sva #(
	parameter int FW = 13,
	parameter int DW = 6,
	parameter int RW = 15
) (
	input wire logic          clk_sys,
	input wire logic          resetn,
	input wire logic          cfg_start,
	input wire logic [FW-1:0] cfg_adc_clk_mhz,
	input wire logic [DW-1:0] cfg_chip_decimation_ratio,
	input wire logic [RW-1:0] cfg_serial_lane_rate_hmbps,
	input wire logic [4:0]    cfg_octets,
	input wire logic [5:0]    cfg_frames,
	input wire logic          busy,
	input wire logic          done,
	input wire logic          cfg_ok,
	input wire jcc_pkg::jcc_err_t err_flags,
	input wire logic [7:0]    band_value,
	input wire logic          dev_wr_stb,
	input wire logic [15:0]   dev_addr,
	input wire logic [7:0]    dev_wdata
);
	import jcc_pkg::*;
	// ********
	// Capture of the request fields
	// ********
	logic [31:0] slr_reg, slr_next, fadc_reg, fadc_next, kf_reg, kf_next, k_reg, k_next;
	// Fields latched on an accepted start
	always_comb begin
		slr_next = slr_reg;
		fadc_next = fadc_reg;
		kf_next = kf_reg;
		k_next = k_reg;
		if (cfg_start && !busy) begin
			slr_next = 32'(cfg_serial_lane_rate_hmbps);
			fadc_next = 32'(cfg_adc_clk_mhz);
			kf_next = 32'(cfg_frames) * 32'(cfg_octets);
			k_next = 32'(cfg_frames);
		end
	end
	// Capture registers
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			slr_reg <= 32'h0000_0000;
			fadc_reg <= 32'h0000_0000;
			kf_reg <= 32'h0000_0000;
			k_reg <= 32'h0000_0000;
		end else begin
			slr_reg <= slr_next;
			fadc_reg <= fadc_next;
			kf_reg <= kf_next;
			k_reg <= k_next;
		end
	end
	// ********
	// Properties
	// ********
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	a_start_busy: assert property (cfg_start && !busy |=> busy && !cfg_ok) else $error("start not taken");
	a_done_bound: assert property (cfg_start && !busy |-> ##[2:120] done) else $error("no done");
	a_done_idle: assert property (done |=> !busy) else $error("busy after done");
	a_write_done: assert property (dev_wr_stb |=> done && cfg_ok) else $error("write without pass");
	a_write_addr: assert property (dev_wr_stb |-> dev_addr == 16'h056E && dev_wdata == band_value)
		else $error("bad write");
	a_ok_write: assert property (done |-> cfg_ok == $past(dev_wr_stb) && cfg_ok == (err_flags == 8'h00))
		else $error("verdict mismatch");
	a_slr_range: assert property (done && cfg_ok |-> slr_reg >= 3375 && slr_reg <= 31000)
		else $error("lane rate out of span");
	a_slr_clock: assert property (done && cfg_ok |-> slr_reg <= 80 * fadc_reg)
		else $error("lane rate over clock");
	a_band_code: assert property (done && cfg_ok |-> band_value ==
		(slr_reg > 27000 ? 8'h30 : slr_reg >= 6750 ? 8'h10 : 8'h00)) else $error("bad band");
	a_kf_rule: assert property (done && cfg_ok |-> kf_reg % 4 == 0 && k_reg <= 32)
		else $error("bad frame count");
endmodule : jcc_link_checker_sva

bind jcc_link_checker jcc_link_checker_sva #(.FW(FW), .DW(DW), .RW(RW)) i_sva (
	.clk_sys(clk_sys), .resetn(resetn), .cfg_start(cfg_start), .cfg_adc_clk_mhz(cfg_adc_clk_mhz),
	.cfg_chip_decimation_ratio(cfg_chip_decimation_ratio), .cfg_serial_lane_rate_hmbps(cfg_serial_lane_rate_hmbps),
	.cfg_octets(cfg_octets), .cfg_frames(cfg_frames), .busy(busy), .done(done), .cfg_ok(cfg_ok),
	.err_flags(err_flags), .band_value(band_value), .dev_wr_stb(dev_wr_stb), .dev_addr(dev_addr),
	.dev_wdata(dev_wdata));

// >>> sim/jcc_dev_model.sv
// Converter register model holding the serializer rate-band register
// Assumes a strobed write port with no acknowledge
`timescale 1ns/100ps
module jcc_dev_model (
	input wire logic         clk_sys,
	input wire logic         resetn,
	input wire logic         dev_wr_stb,
	input wire logic [15:0]  dev_addr,
	input wire logic [7:0]   dev_wdata,
	output logic [7:0]       serdes_rate_band_select_reg,
	output logic [31:0]      wr_count
);
	logic [7:0]  band_next;
	logic [31:0] cnt_next;
	// Band code taken on the strobe cycle, other addresses ignored
	always_comb begin
		band_next = serdes_rate_band_select_reg;
		cnt_next = wr_count;
		if (dev_wr_stb && dev_addr == 16'h056E) begin
			band_next = dev_wdata;
			cnt_next = wr_count + 32'h0000_0001;
		end
	end
	// Register state
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			serdes_rate_band_select_reg <= 8'h00;
			wr_count <= 32'h0000_0000;
		end else begin
			serdes_rate_band_select_reg <= band_next;
			wr_count <= cnt_next;
		end
	end
endmodule : jcc_dev_model

// >>> sim/jcc_link_checker_test.sv
// Self-checking bench of the link configuration checker
// Assumes the device model on the write port
`timescale 1ns/100ps
module jcc_link_checker_test;
	import jcc_pkg::*;
	logic clk_sys = 1'b0, resetn = 1'b0, cfg_start = 1'b0, cfg_hd = 1'b0, busy, done, cfg_ok, dev_wr_stb;
	logic [12:0] cfg_adc_clk_mhz = 13'h0000;
	logic [5:0] cfg_chip_decimation_ratio = 6'h00, cfg_frames = 6'h00;
	logic [14:0] cfg_serial_lane_rate_hmbps = 15'h0000;
	logic [4:0] cfg_lanes = 5'h00, cfg_convs = 5'h00, cfg_octets = 5'h00, cfg_res = 5'h00, cfg_word = 5'h00;
	logic [3:0] cfg_samples = 4'h0;
	logic [1:0] cfg_ctrl_bits = 2'h0;
	jcc_err_t err_flags;
	logic [7:0] band_value, dev_wdata, band_reg;
	logic [15:0] dev_addr;
	logic [31:0] wr_count;
	int error_cnt = 0, check_count = 0, cyc = 0, tnum = 0;
	// ********
	// Design and device model
	// ********
	jcc_link_checker i_dut (.clk_sys(clk_sys), .resetn(resetn), .cfg_start(cfg_start),
		.cfg_adc_clk_mhz(cfg_adc_clk_mhz), .cfg_chip_decimation_ratio(cfg_chip_decimation_ratio),
		.cfg_serial_lane_rate_hmbps(cfg_serial_lane_rate_hmbps), .cfg_lanes(cfg_lanes), .cfg_convs(cfg_convs),
		.cfg_octets(cfg_octets), .cfg_samples(cfg_samples), .cfg_hd(cfg_hd), .cfg_res(cfg_res), .cfg_word(cfg_word),
		.cfg_ctrl_bits(cfg_ctrl_bits), .cfg_frames(cfg_frames), .busy(busy), .done(done), .cfg_ok(cfg_ok),
		.err_flags(err_flags), .band_value(band_value), .dev_wr_stb(dev_wr_stb), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata));
	jcc_dev_model i_dev (.clk_sys(clk_sys), .resetn(resetn), .dev_wr_stb(dev_wr_stb), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .serdes_rate_band_select_reg(band_reg), .wr_count(wr_count));
	// Clock and hang guard
	always #2.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// ********
	// Expectations and checks
	// ********
	function automatic logic [7:0] exp_band(input int serial_lane_rate);
		return serial_lane_rate > 27000 ? 8'h30 : serial_lane_rate >= 6750 ? 8'h10 : 8'h00;
	endfunction : exp_band
	function automatic logic exp_ok(input int fadc, chip_decimation_ratio, serial_lane_rate, k, n, l);
		int lim;
		lim = serial_lane_rate < 6750 ? 24 : serial_lane_rate < 13500 ? 16 : serial_lane_rate <= 27000 ? 8 : 4;
		return serial_lane_rate >= 3375 && serial_lane_rate <= 31000 && serial_lane_rate <= 80 * fadc && fadc % chip_decimation_ratio == 0 && serial_lane_rate == 40 * fadc / chip_decimation_ratio
			&& chip_decimation_ratio % 2 == 0 && chip_decimation_ratio <= lim && chip_decimation_ratio != 14 && chip_decimation_ratio != 18 && chip_decimation_ratio != 22 && k % 4 == 0 && k >= 8
			&& k <= 32 && n >= 8 && n <= 16 && l == 8;
	endfunction : exp_ok
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	// One check request, with a refused start while busy
	// Mode word md is {F, S, HD, N', M}; xok of 0 or 1 overrides the 8x8 expectation
	task automatic run(input int fadc, chip_decimation_ratio, serial_lane_rate, k, n, l,
		input logic [19:0] md = {5'h04, 4'h2, 1'b0, 5'h10, 5'h08}, input int xok = -1);
		logic ok;
		int wc, w;
		ok = (xok >= 0) ? xok[0] : exp_ok(fadc, chip_decimation_ratio, serial_lane_rate, k, n, l);
		wc = wr_count;
		@(posedge clk_sys);
		#1;
		{cfg_adc_clk_mhz, cfg_chip_decimation_ratio, cfg_serial_lane_rate_hmbps} = {fadc[12:0], chip_decimation_ratio[5:0], serial_lane_rate[14:0]};
		{cfg_frames, cfg_res, cfg_lanes, cfg_convs} = {k[5:0], n[4:0], l[4:0], md[4:0]};
		{cfg_octets, cfg_samples, cfg_hd, cfg_word, cfg_ctrl_bits} = {md[19:15], md[14:11], md[10], md[9:5], 2'($urandom)};
		cfg_start = 1'b1;
		@(posedge clk_sys);
		#1;
		cfg_start = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
		cfg_start = 1'b1;
		{cfg_frames, cfg_lanes, cfg_octets, cfg_hd, cfg_samples} = 21'($urandom);
		@(posedge clk_sys);
		#1;
		cfg_start = 1'b0;
		w = 0;
		while (done !== 1'b1 && w < 200) begin
			@(posedge clk_sys);
			#1;
			w++;
		end
		check("done", 32'(done), 32'h1);
		check("cfg_ok", 32'(cfg_ok), 32'(ok));
		check("err", 32'(err_flags != 8'h00), 32'(!ok));
		check("writes", wr_count, wc + 32'(ok));
		if (ok) begin
			check("band", 32'(band_value), 32'(exp_band(serial_lane_rate)));
			check("reg", 32'(band_reg), 32'(exp_band(serial_lane_rate)));
		end
		tnum++;
		$display("test %0d ended", tnum);
	endtask : run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict
	// ********
	// Main sequence
	// ********
	initial begin
		int fo, d;
		void'($urandom(32'hba6b78e2));
		repeat (20) @(posedge clk_sys);
		#1;
		resetn = 1'b1;
		run(1000, 2, 20000, 8, 16, 8);
		run(1500, 2, 30000, 32, 8, 8);
		run(300, 2, 6000, 8, 12, 8);
		run(500, 2, 10000, 12, 9, 8);
		run(1350, 2, 27000, 8, 16, 8);
		run(1600, 2, 32000, 8, 16, 8);
		run(1000, 2, 20000, 4, 16, 8);
		run(4500, 6, 30000, 8, 16, 8);
		run(1000, 2, 18000, 8, 16, 8);
		run(1000, 2, 20000, 8, 17, 8);
		run(1000, 2, 20000, 8, 16, 4);
		run(1500, 3, 15000, 8, 12, 1, {5'h03, 4'h2, 1'b0, 5'h0C, 5'h01}, 1);
		run(1500, 3, 15000, 8, 13, 1, {5'h03, 4'h2, 1'b0, 5'h0C, 5'h01}, 0);
		for (int i = 0; i < 40; i++) begin
			fo = 80 + $urandom % 700;
			d = 2 * (1 + $urandom % 4);
			run(fo * d, d, 40 * fo, 4 * (1 + $urandom % 8), 8 + $urandom % 9, 8);
		end
		print_verdict();
	end
endmodule : jcc_link_checker_test
